// ---- verilog/ebwc_top.sv ----
// external bus controller with wait-state generation and hold arbitration
`timescale 1ns/100ps
module ebwc_top (
  // clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               rst_in,
  // operating mode straps
  input  wire ebwc_pkg::ebwc_mode_t mode_in,
  input  wire logic               boot_mode_in,
  // axi4-lite slave
  input  wire logic [11:0]        s_axi_awaddr_in,
  input  wire logic               s_axi_awvalid_in,
  output logic                    s_axi_awready_out,
  input  wire logic [31:0]        s_axi_wdata_in,
  input  wire logic [3:0]         s_axi_wstrb_in,
  input  wire logic               s_axi_wvalid_in,
  output logic                    s_axi_wready_out,
  output logic [1:0]              s_axi_bresp_out,
  output logic                    s_axi_bvalid_out,
  input  wire logic               s_axi_bready_in,
  input  wire logic [11:0]        s_axi_araddr_in,
  input  wire logic               s_axi_arvalid_in,
  output logic                    s_axi_arready_out,
  output logic [31:0]             s_axi_rdata_out,
  output logic [1:0]              s_axi_rresp_out,
  output logic                    s_axi_rvalid_out,
  input  wire logic               s_axi_rready_in,
  // cpu-side external access request
  input  wire logic               req_valid_in,
  input  wire ebwc_pkg::ebwc_req_t req_in,
  output logic                    req_ready_out,
  output logic                    rsp_valid_out,
  output logic [15:0]             rsp_rdata_out,
  // external bus pins
  output ebwc_pkg::ebwc_pins_t    pins_out,
  output logic                    pins_oe_n_out,
  output logic                    data_oe_n_out,
  input  wire logic [15:0]        data_in,
  input  wire logic               wait_n_in,
  input  wire logic               bus_hold_request_n_in,
  output logic                    bus_hold_grant_n_out
);
  //////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_T1   = 3'h1,
    ST_WAIT = 3'h2,
    ST_DONE = 3'h3,
    ST_HOLD = 3'h4
  } ebwc_state_t;

  ebwc_state_t         state;
  logic [7:0]          wait_count_control;
  logic [15:0]         bus_style_control;
  logic                wait_n_s;
  logic                bus_hold_request_n_n_s;
  logic [2:0]          wcnt;
  logic                bclk;
  ebwc_pkg::ebwc_req_t cur;
  logic                cur_area0;
  logic                cur_area1;

  ebwc_sync #(.RESET_VAL(1'b1)) u_sync_wait (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   (wait_n_in),
    .sync_out   (wait_n_s)
  );

  ebwc_sync #(.RESET_VAL(1'b1)) u_sync_bus_hold_request_n (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   (bus_hold_request_n_in),
    .sync_out   (bus_hold_request_n_n_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // register bus
  logic aw_hold, w_hold;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire  wr_fire   = aw_hold & w_hold & ~s_axi_bvalid_out;
  wire  wr_wtc    = aw_addr == ebwc_pkg::WAIT_COUNT_CONTROL_ADR;
  wire  wr_bsc    = aw_addr == ebwc_pkg::BUS_STYLE_CONTROL_ADR;
  wire  rd_fire   = s_axi_arvalid_in & s_axi_arready_out;
  wire  rd_wtc    = s_axi_araddr_in == ebwc_pkg::WAIT_COUNT_CONTROL_ADR;
  wire  rd_bsc    = s_axi_araddr_in == ebwc_pkg::BUS_STYLE_CONTROL_ADR;
  wire [31:0] rd_val = rd_wtc ? {24'h000000, wait_count_control & 8'hCC}
                     : rd_bsc ? {16'h0000, bus_style_control & 16'h8000}
                     : 32'h00000000;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= ebwc_pkg::AXI_OKAY;
      wait_count_control <= ebwc_pkg::WAIT_COUNT_RESET;
      bus_style_control  <= ebwc_pkg::BUS_STYLE_RESET;
    end else begin
      s_axi_awready_out <= ~aw_hold & ~s_axi_awready_out & ~s_axi_bvalid_out;
      s_axi_wready_out  <= ~w_hold & ~s_axi_wready_out & ~s_axi_bvalid_out;
      if (s_axi_awvalid_in & s_axi_awready_out) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in & s_axi_wready_out) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        aw_hold          <= 1'b0;
        w_hold           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= (wr_wtc | wr_bsc) ? ebwc_pkg::AXI_OKAY : ebwc_pkg::AXI_SLVERR;
        if (wr_wtc && w_strb[0]) begin
          wait_count_control <= w_data[7:0] & 8'hCC;
        end
        if (wr_bsc && w_strb[1]) begin
          bus_style_control <= {w_data[15], 15'h0000};
        end
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= ebwc_pkg::AXI_OKAY;
    end else begin
      s_axi_arready_out <= ~s_axi_arready_out & ~s_axi_rvalid_out & s_axi_arvalid_in;
      if (rd_fire) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= rd_val;
        s_axi_rresp_out  <= (rd_wtc | rd_bsc) ? ebwc_pkg::AXI_OKAY : ebwc_pkg::AXI_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // address decode and wait selection
  wire        ext_mode  = mode_in != ebwc_pkg::EBWC_SINGLE;
  wire [11:0] req_mb    = req_in.addr[31:20];
  wire        dec_area0 = ext_mode & ((req_mb == ebwc_pkg::AREA0_EXT_BASE)
                        | ((mode_in == ebwc_pkg::EBWC_PROC) & (req_mb == ebwc_pkg::AREA0_PROC_BASE)));
  wire        dec_area1 = ext_mode & ((req_mb == ebwc_pkg::AREA1_BASE)
                        | (req_mb == ebwc_pkg::AREA1_ALIAS));
  wire [1:0]  a0_field  = wait_count_control[ebwc_pkg::AREA0_WTC_LSB +: 2];
  wire [1:0]  a1_field  = wait_count_control[ebwc_pkg::AREA1_WTC_LSB +: 2];
  wire [2:0]  a0_waits  = 3'h4 - {1'b0, a0_field};
  wire [2:0]  a1_waits  = 3'h4 - {1'b0, a1_field};
  wire        style_be  = bus_style_control[ebwc_pkg::STYLE_BIT] & ~boot_mode_in;
  wire        last_wait = wcnt == 3'h1;
  wire        start     = req_valid_in & req_ready_out & (dec_area0 | dec_area1);
  wire        hold_go   = ~bus_hold_request_n_n_s & (state == ST_IDLE) & ~start;
  wire        rsp_now   = req_valid_in & req_ready_out & ~(dec_area0 | dec_area1);

  //////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer, one state per bus clock phase
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      wcnt  <= 3'h0;
      cur   <= '0;
      cur_area0 <= 1'b0;
      cur_area1 <= 1'b0;
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 16'h0000;
      bus_hold_grant_n_out <= 1'b1;
    end else begin
      rsp_valid_out <= 1'b0;
      req_ready_out <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          req_ready_out <= ~req_ready_out & bus_hold_request_n_n_s;
          if (start) begin
            state <= ST_T1;
            cur   <= req_in;
            cur_area0 <= dec_area0;
            cur_area1 <= dec_area1;
            wcnt  <= dec_area0 ? a0_waits : a1_waits;
          end else if (rsp_now) begin
            rsp_valid_out <= 1'b1;
            rsp_rdata_out <= 16'h0000;
          end else if (hold_go) begin
            state <= ST_HOLD;
            bus_hold_grant_n_out <= 1'b0;
            req_ready_out <= 1'b0;
          end
        end
        ST_T1: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (!last_wait) begin
            wcnt <= wcnt - 3'h1;
          end else if (wait_n_s) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
          rsp_valid_out <= 1'b1;
          rsp_rdata_out <= cur.write ? 16'h0000
                         : {cur.lanes[1] ? data_in[15:8] : 8'h00,
                            cur.lanes[0] ? data_in[7:0]  : 8'h00};
        end
        ST_HOLD: begin
          if (bus_hold_request_n_n_s) begin
            state <= ST_IDLE;
            bus_hold_grant_n_out <= 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin drivers, registered
  wire active  = (state == ST_T1) | (state == ST_WAIT);
  wire rd_cyc  = active & ~cur.write;
  wire wr_cyc  = active & cur.write & (state == ST_WAIT);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      bclk          <= 1'b0;
      pins_out      <= '1;
      pins_oe_n_out <= 1'b0;
      data_oe_n_out <= 1'b1;
    end else begin
      bclk <= ~bclk;
      pins_out.addr           <= cur.addr[19:1];
      pins_out.dout           <= cur.wdata;
      pins_out.area0_select_n <= ~(active & cur_area0);
      pins_out.area1_select_n <= ~(active & cur_area1);
      pins_out.read_n         <= ~rd_cyc;
      if (style_be) begin
        pins_out.upper_n  <= ~(active & cur.lanes[1]);
        pins_out.lower_n  <= ~(active & cur.lanes[0]);
        pins_out.clk_wr_n <= ~wr_cyc;
      end else begin
        pins_out.upper_n  <= ~(wr_cyc & cur.lanes[1]);
        pins_out.lower_n  <= ~(wr_cyc & cur.lanes[0]);
        pins_out.clk_wr_n <= bclk;
      end
      pins_oe_n_out <= (state == ST_HOLD) | hold_go;
      data_oe_n_out <= ~(active & cur.write) | (state == ST_HOLD);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  AST_GRANT_IN_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ST_HOLD) |-> !bus_hold_grant_n_out)
    else $error("hold grant not low in hold");
  AST_HOLD_TRISTATE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ST_HOLD) |-> pins_oe_n_out && data_oe_n_out)
    else $error("pins driven during hold");
  AST_HOLD_EXIT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ST_HOLD && bus_hold_request_n_n_s) |=> state == ST_IDLE && bus_hold_grant_n_out)
    else $error("hold not left on release");
  AST_MIN_WAIT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ST_T1) |=> state == ST_WAIT)
    else $error("cycle without wait");
  AST_WAIT_EXTEND: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ST_WAIT && last_wait && !wait_n_s) |=> state == ST_WAIT)
    else $error("wait input ignored");
  AST_SOFT_FIRST: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (state == ST_WAIT && !last_wait) |=> state == ST_WAIT && wcnt == $past(wcnt) - 3'h1)
    else $error("programmed waits skipped");
  AST_NO_SINGLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (mode_in == ebwc_pkg::EBWC_SINGLE && state == ST_IDLE) |=> state != ST_T1)
    else $error("external cycle in single-chip mode");
  AST_READ_STROBES: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (rd_cyc && !style_be) |=> pins_out.upper_n && pins_out.lower_n && !pins_out.read_n)
    else $error("write strobe during read");
  AST_WAIT_LOAD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (start && dec_area0) |=> wcnt == 3'h4 - {1'b0, $past(a0_field)})
    else $error("wrong wait count");
endmodule : ebwc_top

// ---- verilog/ebwc_pkg.sv ----
// package for the external bus and wait controller
// Functional notes
// - Style bit 15: 0 per-byte write strobes, 1 byte enables plus shared write.
// - Strobe style drives per-lane write strobes, read strobe, bus clock, wait input.
// - Boot mode forces per-byte write strobe style regardless of style bit.
// - Byte-enable style outputs no bus clock.
// - Strobe style read: read strobe low, both write strobes high, valid lanes taken.
// - Strobe style write: only written lanes' write strobes go low with data.
// - Byte-enable style read: read strobe low, enables of read lanes low.
// - Byte-enable style write: shared write low, enables of written lanes low.
// - Wait cycles continue while the wait input is held low.
// - Every external cycle has at least one wait; shortest is two bus clocks; here T1 and one wait last one bus clock phase each, one bus clock in all.
// - Accepted hold request enters hold and drives hold grant low.
// - In hold all bus pins are released to high impedance.
// - Hold request returning high ends hold and resumes bus operation.
// - Single-chip mode: no target area, wait settings have no effect.
// - Software programs 1 to 4 internal wait cycles per area access.
// - Wait input sampled in last internal wait; low extends that wait.
// - Programmed waits come first, external waits added after.
// - Area 0 at 0x100000 in extension mode, 0x0 plus alias in processor mode.
// - Area 1 at 0x200000 with alias at 0x300000 in both external modes.
// - Chip selects driven only in extension and processor modes.
// - Wait field 00=4,01=3,10=2,11=1; area 0 bits 2-3, area 1 bits 6-7.
package ebwc_pkg;
  localparam logic [23:0] WAIT_COUNT_CONTROL_OFS = 24'h800180;
  localparam logic [23:0] BUS_STYLE_CONTROL_OFS  = 24'h800184;
  localparam logic [11:0] WAIT_COUNT_CONTROL_ADR = 12'h180;
  localparam logic [11:0] BUS_STYLE_CONTROL_ADR  = 12'h184;
  localparam int          STYLE_BIT              = 15;
  localparam int          AREA0_WTC_LSB          = 2;
  localparam int          AREA1_WTC_LSB          = 6;
  localparam logic [7:0]  WAIT_COUNT_RESET       = 8'h00;
  localparam logic [15:0] BUS_STYLE_RESET        = 16'h0000;
  localparam logic [11:0] AREA0_EXT_BASE         = 12'h001;
  localparam logic [11:0] AREA0_PROC_BASE        = 12'h000;
  localparam logic [11:0] AREA1_BASE             = 12'h002;
  localparam logic [11:0] AREA1_ALIAS            = 12'h003;
  localparam logic [1:0]  AXI_OKAY               = 2'h0;
  localparam logic [1:0]  AXI_SLVERR             = 2'h2;

  typedef enum logic [1:0] {
    EBWC_SINGLE = 2'h0,
    EBWC_EXTEND = 2'h1,
    EBWC_PROC   = 2'h2
  } ebwc_mode_t;

  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic [1:0]  lanes;
  } ebwc_req_t;

  typedef struct packed {
    logic [18:0] addr;
    logic [15:0] dout;
    logic        area0_select_n;
    logic        area1_select_n;
    logic        read_n;
    logic        upper_n;
    logic        lower_n;
    logic        clk_wr_n;
  } ebwc_pins_t;
endpackage : ebwc_pkg

// ---- verilog/ebwc_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ebwc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  // async level and its synchronised copy
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stage1   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : ebwc_sync

// ---- tb/ebwc_mem_model.sv ----
// external memory and wait source facing the bus controller
`timescale 1ns/100ps
module ebwc_mem_model (
  // clock, effective bus style and wait stretch length
  input  wire logic                 ref_clk_in,
  input  wire logic                 style_in,
  input  wire logic [7:0]           stretch_in,
  // pins from the controller
  input  wire ebwc_pkg::ebwc_pins_t pins_in,
  input  wire logic                 pins_oe_n_in,
  // pins back to the controller
  output logic [15:0]               data_out,
  output logic                      wait_n_out
);
  logic [15:0] mem [0:255];
  logic [7:0]  cnt = 8'h00;
  logic        sel_q = 1'b0;
  wire  [7:0]  a   = pins_in.addr[7:0];
  wire         sel = !pins_oe_n_in && !(pins_in.area0_select_n && pins_in.area1_select_n);
  wire         wr  = style_in ? !pins_in.clk_wr_n : pins_in.read_n;
  wire         up  = sel && wr && !pins_in.upper_n;
  wire         lo  = sel && wr && !pins_in.lower_n;
  // no stretch request leaves the wait line high
  assign wait_n_out = (cnt == 8'h00);
  initial begin
    data_out = 16'h0000;
    for (int i = 0; i < 256; i++)
      mem[i] = 16'h0000;
  end
  always @(posedge ref_clk_in) begin
    if (up)
      mem[a][15:8] <= pins_in.dout[15:8];
    if (lo)
      mem[a][7:0] <= pins_in.dout[7:0];
    // bus not read shows no stale word; device bit order kept end to end
    data_out <= (sel && !pins_in.read_n) ? mem[a] : ~data_out;
    sel_q <= sel;
    if (sel && !sel_q)
      cnt <= stretch_in;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
endmodule : ebwc_mem_model

// ---- tb/ebwc_top_test.sv ----
// self-checking bench for the external bus controller
`timescale 1ns/100ps
module ebwc_top_test;
  logic                 clk = 0, rst = 1, boot = 0, req_valid = 0, bus_hold_request_n_n = 1, clr = 0;
  logic                 style = 0, pcw = 1;
  ebwc_pkg::ebwc_mode_t mode = ebwc_pkg::EBWC_EXTEND;
  ebwc_pkg::ebwc_req_t  req = '0;
  ebwc_pkg::ebwc_pins_t pins;
  logic [11:0]          awaddr = 0, araddr = 0;
  logic [31:0]          wdata = 0, rdata;
  logic [1:0]           bresp, rresp;
  logic                 awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic                 awr, wrdy, bv, arr, rv, req_ready, rsp_v, oe_n, doe_n, grant_n, wait_n;
  logic [15:0]          rsp_d, dbus, shadow [0:255];
  logic [7:0]           stretch = 0;
  logic [5:0]           seen = 0;
  logic                 dwr = 0;
  logic [3:0]           wstrb = 4'hF;
  int                   fail_count = 0, total_checks = 0, cyc = 0, togs = 0, rdc = 0;
  wire                  style_eff = style & !boot;

  ebwc_top i_dut (.ref_clk_in(clk), .rst_in(rst), .mode_in(mode), .boot_mode_in(boot),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rready), .req_valid_in(req_valid),
    .req_in(req), .req_ready_out(req_ready), .rsp_valid_out(rsp_v),
    .rsp_rdata_out(rsp_d), .pins_out(pins), .pins_oe_n_out(oe_n),
    .data_oe_n_out(doe_n), .data_in(dbus), .wait_n_in(wait_n),
    .bus_hold_request_n_in(bus_hold_request_n_n), .bus_hold_grant_n_out(grant_n));
  ebwc_mem_model i_mem (.ref_clk_in(clk), .style_in(style_eff), .stretch_in(stretch),
    .pins_in(pins), .pins_oe_n_in(oe_n), .data_out(dbus), .wait_n_out(wait_n));

  ////////////////////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  always @(posedge clk) begin
    pcw <= pins.clk_wr_n;
    if (pcw !== pins.clk_wr_n)
      togs++;
    rdc <= clr ? 0 : rdc + int'(!oe_n && !pins.read_n);
    seen <= clr ? 6'h00 : seen | ({6{!oe_n}} & {!pins.area1_select_n, !pins.area0_select_n,
      !pins.read_n, !pins.upper_n, !pins.lower_n, style_eff & !pins.clk_wr_n});
    dwr <= clr ? 1'b0 : dwr | !doe_n;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata  <= d;
    awv    <= 1;
    wv     <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awv && awr)
        awv <= 0;
      if (wv && wrdy)
        wv <= 0;
    end while (!bv);
    r = bresp;
    bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arv    <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (arv && arr)
        arv <= 0;
    end while (!rv);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask : axi_rd
  task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] wd,
                     input logic [1:0] ln, output logic [15:0] rd, output int lat);
    int n;
    n = 0;
    @(posedge clk);
    req       <= '{w, a, wd, ln};
    req_valid <= 1;
    clr       <= 1;
    do begin
      @(posedge clk);
      clr <= 0;
      n++;
    end while (!req_ready && n < 60);
    if (!req_ready)
      fail_count++;
    req_valid <= 0;
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (!rsp_v && lat < 300);
    if (!rsp_v)
      fail_count++;
    rd = rsp_d;
  endtask : acc
  function automatic logic [5:0] exp_seen(logic w, logic ar, logic [1:0] ln, logic st);
    return {ar, !ar, !w, ln[1] & (w | st), ln[0] & (w | st), w & st};
  endfunction : exp_seen
  function automatic logic [31:0] place(logic ar, logic al, logic [7:0] ix);
    logic [31:0] b;
    b = ar ? (al ? 32'h0030_0000 : 32'h0020_0000) :
        ((mode == ebwc_pkg::EBWC_PROC && !al) ? 32'h0000_0000 : 32'h0010_0000);
    return b | {23'h0, ix, 1'b0};
  endfunction : place

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d, q;
    logic [1:0]  r, ln;
    logic [15:0] rd, v;
    logic        w, ar, al;
    logic [7:0]  ix;
    int          l0, l1, base, t0;
    void'($urandom(94));
    for (int i = 0; i < 256; i++)
      shadow[i] = 16'h0000;
    repeat (2) @(posedge clk);
    rst <= 0;
    axi_rd(12'h180, d, r);
    chk("wait_ctl_reset", d, 32'h0);
    axi_rd(12'h184, d, r);
    chk("style_reset", d, 32'h0);
    axi_rd(12'h1F0, d, r);
    chk("unmapped_rd", {30'h0, r}, {30'h0, ebwc_pkg::AXI_SLVERR});
    axi_wr(12'h1F0, 32'h1, r);
    chk("unmapped_wr", {30'h0, r}, {30'h0, ebwc_pkg::AXI_SLVERR});
    // area 0 code c, area 1 code 3-c
    for (int c = 0; c < 4; c++) begin
      d = 32'(c << 2) | 32'((3 - c) << 6) | ($urandom & 32'hFFFF_FF33);
      axi_wr(12'h180, d, r);
      axi_rd(12'h180, q, r);
      chk("wait_ctl_rdback", q, d & 32'h0000_00CC);
      acc(1'b0, place(1'b0, 1'b0, 8'h10), 16'h0, 2'h3, rd, l0);
      chk("rd_low_min", 32'(rdc >= 2), 32'h1);
      acc(1'b0, place(1'b1, 1'b0, 8'h10), 16'h0, 2'h3, rd, l1);
      chk("wait_diff", 32'(l0 - l1), 32'(3 - 2 * c));
      if (c == 0)
        base = l0;
      chk("wait_scale", 32'(base - l0), 32'(c));
    end
    // write without its byte strobe leaves the wait fields alone
    wstrb <= 4'h0;
    axi_wr(12'h180, 32'hFF, r);
    wstrb <= 4'hF;
    axi_rd(12'h180, q, r);
    chk("wait_ctl_nostrb", q, d & 32'h0000_00CC);
    for (int i = 0; i < 48; i++) begin
      mode <= i[2] ? ebwc_pkg::EBWC_PROC : ebwc_pkg::EBWC_EXTEND;
      boot <= (i % 6 == 5);
      axi_wr(12'h184, 32'(i[0]) << 15, r);
      style <= i[0];
      w  = 1'($urandom);
      ar = 1'($urandom);
      al = 1'($urandom);
      ix = 8'($urandom);
      v  = 16'($urandom);
      ln = 2'($urandom_range(3, 1));
      t0 = togs;
      acc(w, place(ar, al, ix), v, ln, rd, l0);
      if (w && ln[1])
        shadow[ix][15:8] = v[15:8];
      if (w && ln[0])
        shadow[ix][7:0] = v[7:0];
      chk("rdata", {16'h0, rd}, {16'h0, w ? 16'h0 : v & 16'h0 | shadow[ix] &
          {{8{ln[1]}}, {8{ln[0]}}}});
      chk("strobes", {26'h0, seen}, {26'h0, exp_seen(w, ar, ln, style_eff)});
      chk("data_drive", {31'h0, dwr}, {31'h0, w});
      if (!style_eff)
        chk("bus_clock", 32'(togs > t0), 32'h1);
    end
    mode <= ebwc_pkg::EBWC_SINGLE;
    boot <= 0;
    acc(1'b0, 32'h0010_0000, 16'h0, 2'h3, rd, l0);
    chk("single_lat", 32'(l0), 32'h1);
    chk("single_pins", {26'h0, seen}, 32'h0);
    mode <= ebwc_pkg::EBWC_EXTEND;
    axi_wr(12'h180, 32'h0, r);
    acc(1'b0, place(1'b0, 1'b0, 8'h20), 16'h0, 2'h3, rd, base);
    stretch <= 8'h14;
    acc(1'b0, place(1'b0, 1'b0, 8'h20), 16'h0, 2'h3, rd, l0);
    stretch <= 8'h00;
    chk("stretch", 32'(l0 >= base + 10 && l0 <= base + 24), 32'h1);
    bus_hold_request_n_n <= 0;
    l1 = 0;
    do begin
      @(posedge clk);
      l1++;
    end while (grant_n && l1 < 20);
    req_valid <= 1;
    repeat (8) begin
      @(posedge clk);
      chk("hold", {28'h0, req_ready, oe_n, doe_n, grant_n}, 32'h6);
    end
    req_valid <= 0;
    bus_hold_request_n_n <= 1;
    repeat (8) @(posedge clk);
    chk("hold_end", {31'h0, grant_n}, 32'h1);
    acc(1'b0, place(1'b1, 1'b0, 8'h30), 16'h0, 2'h1, rd, l0);
    chk("resume", {26'h0, seen}, {26'h0, exp_seen(1'b0, 1'b1, 2'h1, style_eff)});
    close_out();
  end
endmodule : ebwc_top_test
